// >>> core/pmu_irq_pkg.sv
// Constants for the power-management interrupt status block.
// Assumes one 100 MHz core clock and a two-wire serial register port.
package pmu_irq_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_IRQ_STATUS_PRIMARY = 8'h00;
    localparam logic [7:0] ADDR_IRQ_STATUS_OVERLOAD = 8'h01;
    localparam logic [7:0] ADDR_IRQ_MASK_PRIMARY = 8'h02;
    localparam logic [7:0] ADDR_IRQ_MASK_OVERLOAD = 8'h03;
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'hFF;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] MASK_PRIMARY_WRITABLE = 8'hFE;

    // ------------------------------------------------------------
    // Field layout over both status registers, primary in bits 7:0
    // ------------------------------------------------------------
    localparam int SUMMARY_IRQ_BIT = 0;
    localparam logic [15:0] LATCHED_BITS = 16'hFFE0;
    localparam logic [15:0] LIVE_BITS = 16'h001E;

    // ------------------------------------------------------------
    // Serial port
    // ------------------------------------------------------------
    localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h48;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_PTR = 3'b010,
        ST_WR = 3'b011,
        ST_ACK = 3'b100,
        ST_RD = 3'b101,
        ST_RD_ACK = 3'b110
    } serial_state_e;

endpackage

// >>> core/pmu_interrupt_status_regs.sv
// Interrupt status and mask registers of a power-management unit,
// reached through a two-wire serial slave port.
// Assumes raw event inputs are asynchronous levels and the serial
// pins are open-drain with external pull-ups resolved by the bench.
//
// Contract
// - A rising converter, switch overload or charge-done flag latches and requests interrupt.
// - Latched flags stay at one until an interrupt clear, then return to zero.
// - Register 0x00 holds buck2, buck1, done, active, three rails, summary; resets zero.
// - Register 0x01 holds switch seven to one overloads and buck3; read-only, resets zero.
// - Summary bit reads one while asserted; writing zero to it clears pending interrupts.
// - Mask registers 0x02 and 0x03 enable each flag's interrupt; reset to zero.
// - Reads of undefined register addresses return FFh.
`timescale 1ns/100ps
`default_nettype none

module pmu_interrupt_status_regs
    import pmu_irq_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEFAULT
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic NRST,
    // Raw event levels, asynchronous
    input wire logic BUCK1_OVERLOAD_FLAG,
    input wire logic BUCK2_OVERLOAD_FLAG,
    input wire logic BUCK3_OVERLOAD_FLAG,
    input wire logic [7:1] SWITCH_OVERLOAD_FLAG,
    input wire logic CHARGE_DONE_FLAG,
    input wire logic CHARGING_ACTIVE_FLAG,
    input wire logic BATTERY_GOOD_FLAG,
    input wire logic SYSTEM_RAIL_GOOD_FLAG,
    input wire logic ADAPTER_GOOD_FLAG,
    // Serial register port, open drain
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    // Summary interrupt request
    output logic IRQ_REQ
);

    // ------------------------------------------------------------
    // Event synchronisers and edge detection
    // ------------------------------------------------------------
    logic [15:0] raw;
    logic [15:0] ev_s1_q, ev_s2_q, ev_s3_q;
    logic [15:0] rise, change, event_vec, rise_lat;

    assign raw = {SWITCH_OVERLOAD_FLAG, BUCK3_OVERLOAD_FLAG, BUCK2_OVERLOAD_FLAG,
                  BUCK1_OVERLOAD_FLAG, CHARGE_DONE_FLAG, CHARGING_ACTIVE_FLAG,
                  BATTERY_GOOD_FLAG, SYSTEM_RAIL_GOOD_FLAG, ADAPTER_GOOD_FLAG, 1'b0};

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            {ev_s1_q, ev_s2_q, ev_s3_q} <= 48'h000000000000;
        end else begin
            {ev_s1_q, ev_s2_q, ev_s3_q} <= {raw, ev_s1_q, ev_s2_q};
        end
    end

    assign rise = ev_s2_q & ~ev_s3_q;
    assign change = ev_s2_q ^ ev_s3_q;
    assign rise_lat = rise & LATCHED_BITS;
    assign event_vec = rise_lat | (change & LIVE_BITS);

    // ------------------------------------------------------------
    // Latched flags, masks and summary interrupt
    // ------------------------------------------------------------
    logic [15:0] latched_q, latched_d;
    logic [7:0] mask_pri_q, mask_ovl_q;
    logic [15:0] mask16;
    logic irq_q, irq_d;
    logic clear_pulse, wr_pulse;
    logic [7:0] wr_data, ptr_q;

    assign mask16 = {mask_ovl_q, mask_pri_q};

    // Set wins over a clear in the same cycle
    always_comb begin
        latched_d = (latched_q & ~{16{clear_pulse}}) | rise_lat;
        irq_d = irq_q & ~clear_pulse;
        if ((event_vec & mask16) != 16'h0000) begin
            irq_d = 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            latched_q <= 16'h0000;
            irq_q <= 1'b0;
        end else begin
            latched_q <= latched_d;
            irq_q <= irq_d;
        end
    end

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            mask_pri_q <= MASK_RESET;
            mask_ovl_q <= MASK_RESET;
        end else if (wr_pulse && ptr_q == ADDR_IRQ_MASK_PRIMARY) begin
            mask_pri_q <= wr_data & MASK_PRIMARY_WRITABLE;
        end else if (wr_pulse && ptr_q == ADDR_IRQ_MASK_OVERLOAD) begin
            mask_ovl_q <= wr_data;
        end
    end

    // Writing zero to the summary bit clears; other status bits ignore writes
    assign clear_pulse = wr_pulse && ptr_q == ADDR_IRQ_STATUS_PRIMARY
                         && !wr_data[SUMMARY_IRQ_BIT];
    assign IRQ_REQ = irq_q;

    function automatic logic [7:0] read_reg(input logic [7:0] addr);
        logic [15:0] st;
        st = (latched_q & LATCHED_BITS) | (ev_s3_q & LIVE_BITS);
        st[SUMMARY_IRQ_BIT] = irq_q;
        case (addr)
            ADDR_IRQ_STATUS_PRIMARY: read_reg = st[7:0];
            ADDR_IRQ_STATUS_OVERLOAD: read_reg = st[15:8];
            ADDR_IRQ_MASK_PRIMARY: read_reg = mask_pri_q;
            ADDR_IRQ_MASK_OVERLOAD: read_reg = mask_ovl_q;
            default: read_reg = UNMAPPED_READ_VALUE;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Serial slave: pin synchronisers and bus conditions
    // ------------------------------------------------------------
    logic scl_s1_q, scl_s2_q, scl_s3_q, sda_s1_q, sda_s2_q, sda_s3_q;
    logic scl_rise, scl_fall, start_cond, stop_cond;

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            {scl_s1_q, scl_s2_q, scl_s3_q} <= 3'b111;
            {sda_s1_q, sda_s2_q, sda_s3_q} <= 3'b111;
        end else begin
            {scl_s1_q, scl_s2_q, scl_s3_q} <= {SCL_IN, scl_s1_q, scl_s2_q};
            {sda_s1_q, sda_s2_q, sda_s3_q} <= {SDA_IN, sda_s1_q, sda_s2_q};
        end
    end

    assign scl_rise = scl_s2_q && !scl_s3_q;
    assign scl_fall = !scl_s2_q && scl_s3_q;
    assign start_cond = scl_s2_q && scl_s3_q && !sda_s2_q && sda_s3_q;
    assign stop_cond = scl_s2_q && scl_s3_q && sda_s2_q && !sda_s3_q;

    // ------------------------------------------------------------
    // Serial slave: byte engine
    // ------------------------------------------------------------
    serial_state_e state_q, after_ack_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    logic master_ack_q;
    logic load_rd;

    assign load_rd = scl_fall && ((state_q == ST_ACK && after_ack_q == ST_RD)
                     || (state_q == ST_RD_ACK && master_ack_q));
    assign wr_pulse = scl_fall && state_q == ST_WR && cnt_q == BITS_PER_BYTE;
    assign wr_data = sh_q;

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            state_q <= ST_IDLE;
            after_ack_q <= ST_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            ptr_q <= 8'h00;
            master_ack_q <= 1'b0;
        end else if (start_cond) begin
            state_q <= ST_ADDR;
            cnt_q <= 4'h0;
        end else if (stop_cond) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_ADDR, ST_PTR, ST_WR: begin
                    if (scl_rise) begin
                        sh_q <= {sh_q[6:0], sda_s2_q};
                        cnt_q <= cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
                        cnt_q <= 4'h0;
                        state_q <= ST_ACK;
                        if (state_q == ST_ADDR) begin
                            if (sh_q[7:1] != SLAVE_ADDR) begin
                                state_q <= ST_IDLE;
                            end
                            after_ack_q <= sh_q[0] ? ST_RD : ST_PTR;
                        end else if (state_q == ST_PTR) begin
                            ptr_q <= sh_q;
                            after_ack_q <= ST_WR;
                        end else begin
                            ptr_q <= ptr_q + 8'h01;
                            after_ack_q <= ST_WR;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        state_q <= after_ack_q;
                        cnt_q <= 4'h0;
                        if (load_rd) begin
                            sh_q <= read_reg(ptr_q);
                            ptr_q <= ptr_q + 8'h01;
                        end
                    end
                end
                ST_RD: begin
                    if (scl_fall) begin
                        if (cnt_q == BITS_PER_BYTE - 4'h1) begin
                            state_q <= ST_RD_ACK;
                            cnt_q <= 4'h0;
                        end else begin
                            sh_q <= {sh_q[6:0], 1'b1};
                            cnt_q <= cnt_q + 4'h1;
                        end
                    end
                end
                ST_RD_ACK: begin
                    if (scl_rise) begin
                        master_ack_q <= !sda_s2_q;
                    end else if (scl_fall) begin
                        state_q <= master_ack_q ? ST_RD : ST_IDLE;
                        if (load_rd) begin
                            sh_q <= read_reg(ptr_q);
                            ptr_q <= ptr_q + 8'h01;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    assign SDA_OUT = 1'b0;
    assign SDA_OE = (state_q == ST_ACK) || (state_q == ST_RD && !sh_q[7]);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);

    sequence s_rise_seen;
        rise_lat != 16'h0000;
    endsequence
    sequence s_enabled_event;
        (event_vec & mask16) != 16'h0000;
    endsequence
    property p_latch_set;
        s_rise_seen |=> ((latched_q & $past(rise_lat)) == $past(rise_lat));
    endproperty
    a_latch_set: assert property (p_latch_set) else $error("rising flag not latched");
    property p_latch_hold;
        !clear_pulse |=> ((latched_q & $past(latched_q)) == $past(latched_q));
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched flag lost");
    property p_latch_clear;
        (clear_pulse && rise_lat == 16'h0000) |=> latched_q == 16'h0000;
    endproperty
    a_latch_clear: assert property (p_latch_clear) else $error("clear left flags set");
    property p_live_change;
        ((change & LIVE_BITS & mask16) != 16'h0000) |=> irq_q;
    endproperty
    a_live_change: assert property (p_live_change) else $error("live change missed");
    property p_irq_raise;
        s_enabled_event |=> irq_q;
    endproperty
    a_irq_raise: assert property (p_irq_raise) else $error("enabled event gave no irq");
    property p_irq_hold;
        (irq_q && !clear_pulse) |=> irq_q;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without clear");
    property p_irq_clear;
        (clear_pulse && (event_vec & mask16) == 16'h0000) |=> !irq_q [*2] or (!irq_q ##1 irq_q);
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("irq not cleared");
    property p_mask_gate;
        (!irq_q && (event_vec & mask16) == 16'h0000) |=> !irq_q;
    endproperty
    a_mask_gate: assert property (p_mask_gate) else $error("masked event raised irq");
    property p_unmapped;
        (load_rd && ptr_q > ADDR_IRQ_MASK_OVERLOAD) |=> sh_q == UNMAPPED_READ_VALUE;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not FFh");
    property p_overload_map;
        (load_rd && ptr_q == ADDR_IRQ_STATUS_OVERLOAD) |=> sh_q == $past(latched_q[15:8]);
    endproperty
    a_overload_map: assert property (p_overload_map) else $error("overload byte wrong");

endmodule

`default_nettype wire

// >>> verification/host_serial_master.sv
// Host-side two-wire serial master that reads and writes the registers.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/100ps
`default_nettype none

module host_serial_master
    import pmu_irq_pkg::*;
(
    // Bench clock
    input wire logic clk,
    // Resolved data line
    input wire logic sda_line,
    // Pin drives, high means released
    output logic scl,
    output logic sda
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    // ------------------------------------------------------------
    // Bit level, quarter periods of four clocks
    // ------------------------------------------------------------
    task automatic step(input logic c, input logic d);
        scl = c;
        sda = d;
        repeat (4) @(negedge clk);
    endtask

    task automatic bit_io(input logic b, output logic r);
        step(1'b0, sda);
        step(1'b0, b);
        step(1'b1, b);
        r = sda_line;
        step(1'b1, b);
    endtask

    task automatic start_cond();
        step(1'b0, sda);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask

    task automatic stop_cond();
        step(1'b0, sda);
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask

    task automatic xbyte(input logic [7:0] d, input logic ai, output logic [7:0] r,
                         output logic ao);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r[i]);
        end
        bit_io(ai, ao);
    endtask

    // ------------------------------------------------------------
    // Register transfers
    // ------------------------------------------------------------
    task automatic wr(input logic [6:0] sa, input logic [7:0] ptr, input logic [7:0] data,
                      output logic [2:0] nak);
        logic [7:0] r;
        start_cond();
        xbyte({sa, 1'b0}, 1'b1, r, nak[2]);
        xbyte(ptr, 1'b1, r, nak[1]);
        xbyte(data, 1'b1, r, nak[0]);
        stop_cond();
    endtask

    task automatic rd(input logic [7:0] ptr, output logic [7:0] data);
        logic [7:0] r;
        logic a;
        start_cond();
        xbyte({SLAVE_ADDR_DEFAULT, 1'b0}, 1'b1, r, a);
        xbyte(ptr, 1'b1, r, a);
        start_cond();
        xbyte({SLAVE_ADDR_DEFAULT, 1'b1}, 1'b1, r, a);
        xbyte(8'hFF, 1'b1, data, a);
        stop_cond();
    endtask

    // Two bytes in one read, acknowledged in between
    task automatic rd2(input logic [7:0] ptr, output logic [7:0] d0, output logic [7:0] d1);
        logic [7:0] r;
        logic a;
        start_cond();
        xbyte({SLAVE_ADDR_DEFAULT, 1'b0}, 1'b1, r, a);
        xbyte(ptr, 1'b1, r, a);
        start_cond();
        xbyte({SLAVE_ADDR_DEFAULT, 1'b1}, 1'b1, r, a);
        xbyte(8'hFF, 1'b0, d0, a);
        xbyte(8'hFF, 1'b1, d1, a);
        stop_cond();
    endtask
endmodule

`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the interrupt status registers.
// Assumes the host model above and a pull-up on the data line.
`timescale 1ns/100ps
`default_nettype none

module testbench
    import pmu_irq_pkg::*;
;
    logic core_clk;
    logic nrst;
    logic [15:0] in_flags;
    logic scl_m, sda_m, sda_out, sda_oe, irq_req, sda_line;
    logic [7:0] exp_p, exp_o, rd_a, rd_b;
    logic [2:0] nak;
    int n_errors = 0;
    int tests_run = 0;

    assign sda_line = sda_m & (sda_oe ? sda_out : 1'b1);

    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;

    pmu_interrupt_status_regs u_pmu_interrupt_status_regs (
        .CORE_CLK(core_clk), .NRST(nrst),
        .BUCK1_OVERLOAD_FLAG(in_flags[6]), .BUCK2_OVERLOAD_FLAG(in_flags[7]),
        .BUCK3_OVERLOAD_FLAG(in_flags[8]), .SWITCH_OVERLOAD_FLAG(in_flags[15:9]),
        .CHARGE_DONE_FLAG(in_flags[5]), .CHARGING_ACTIVE_FLAG(in_flags[4]),
        .BATTERY_GOOD_FLAG(in_flags[3]), .SYSTEM_RAIL_GOOD_FLAG(in_flags[2]),
        .ADAPTER_GOOD_FLAG(in_flags[1]), .SCL_IN(scl_m), .SDA_IN(sda_line),
        .SDA_OUT(sda_out), .SDA_OE(sda_oe), .IRQ_REQ(irq_req)
    );

    host_serial_master u_host_serial_master (
        .clk(core_clk), .sda_line(sda_line), .scl(scl_m), .sda(sda_m)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] exp);
        logic [7:0] d;
        u_host_serial_master.rd(ptr, d);
        check(d, exp);
    endtask

    task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
        u_host_serial_master.wr(SLAVE_ADDR_DEFAULT, ptr, data, nak);
        check({5'h00, nak}, 8'h00);
    endtask

    task automatic set_flags(input logic [15:0] v);
        @(negedge core_clk);
        in_flags = v;
        repeat (10) @(negedge core_clk);
    endtask

    task automatic report_and_stop();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        in_flags = 16'h0000;
        repeat (10) @(negedge core_clk);
        nrst = 1'b1;
        repeat (5) @(negedge core_clk);
        for (int a = 0; a < 5; a++) begin
            rd_chk(a[7:0], (a == 4) ? 8'hFF : 8'h00);
        end
        // Each latched source alone, rising then falling, masks all off
        exp_p = 8'h00;
        exp_o = 8'h00;
        for (int i = 0; i < 16; i++) begin
            if (LATCHED_BITS[i]) begin
                set_flags(16'h0001 << i);
                set_flags(16'h0000);
                if (i < 8) exp_p[i] = 1'b1;
                else exp_o[i - 8] = 1'b1;
                rd_chk(8'h00, exp_p);
                rd_chk(8'h01, exp_o);
                check({7'h00, irq_req}, 8'h00);
            end
        end
        wr(8'h01, 8'h00);
        rd_chk(8'h01, 8'hFF);
        u_host_serial_master.wr(SLAVE_ADDR_DEFAULT ^ 7'h01, 8'h00, 8'h00, nak);
        check({5'h00, nak}, 8'h07);
        wr(8'h00, 8'h01);
        rd_chk(8'h00, 8'hE0);
        wr(8'h00, 8'h00);
        rd_chk(8'h00, 8'h00);
        rd_chk(8'h01, 8'h00);
        wr(8'h02, 8'hFF);
        wr(8'h03, 8'hFF);
        rd_chk(8'h02, 8'hFE);
        rd_chk(8'h03, 8'hFF);
        set_flags(16'h0100);
        check({7'h00, irq_req}, 8'h01);
        set_flags(16'h0000);
        rd_chk(8'h00, 8'h01);
        rd_chk(8'h01, 8'h01);
        u_host_serial_master.rd2(8'h01, rd_a, rd_b);
        check(rd_a, 8'h01);
        check(rd_b, 8'hFE);
        wr(8'h00, 8'h00);
        check({7'h00, irq_req}, 8'h00);
        set_flags(16'h0008);
        check({7'h00, irq_req}, 8'h01);
        wr(8'h00, 8'h00);
        rd_chk(8'h00, 8'h08);
        set_flags(16'h0000);
        rd_chk(8'h00, 8'h01);
        wr(8'h00, 8'h00);
        wr(8'h02, 8'h00);
        set_flags(16'h0002);
        set_flags(16'h0042);
        check({7'h00, irq_req}, 8'h00);
        rd_chk(8'h00, 8'h42);
        // Mid-run reset drops latched flags and masks
        set_flags(16'h0000);
        nrst = 1'b0;
        repeat (3) @(negedge core_clk);
        nrst = 1'b1;
        repeat (5) @(negedge core_clk);
        rd_chk(8'h00, 8'h00);
        rd_chk(8'h03, 8'h00);
        report_and_stop();
    end

    initial begin
        repeat (60000) @(posedge core_clk);
        n_errors++;
        report_and_stop();
    end
endmodule

`default_nettype wire
